// ---- nvsrs_pkg.sv ----
// nvsrs_pkg: constants for the host-side nonvolatile save/restore sequencer
// assumes a 50 MHz system clock and an asynchronous byte-wide memory outside
package nvsrs_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int MATCH_W = 14;
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  // --------------------------------------------------------------
  // sequence addresses
  // --------------------------------------------------------------
  localparam logic [13:0] SEQ_A1 = 14'h0e38;
  localparam logic [13:0] SEQ_A2 = 14'h31c7;
  localparam logic [13:0] SEQ_A3 = 14'h03e0;
  localparam logic [13:0] SEQ_A4 = 14'h3c1f;
  localparam logic [13:0] SEQ_A5 = 14'h303f;
  localparam logic [13:0] SEQ_SAVE = 14'h0fc0;
  localparam logic [13:0] SEQ_RESTORE = 14'h0c63;
  localparam logic [13:0] SEQ_TEST = 14'h339c;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CE_LOW_NS = 20;
  localparam int CE_LOW_CYC = (CE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_NS = 45;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_NS = 20;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIZ_NS = 600;
  localparam int HIZ_CYC = (HIZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAVE_MS = 10;
  localparam int SAVE_CYC = SAVE_MS * 1000 * CLK_MHZ;
  localparam int RESTORE_US = 20;
  localparam int RESTORE_CYC = RESTORE_US * CLK_MHZ;
  localparam int POWERUP_COPY_US = 650;
  localparam int POWERUP_COPY_CYC = POWERUP_COPY_US * CLK_MHZ;
  localparam int WAIT_W = 20;
  typedef enum logic [1:0] {NVSRS_OP_READ, NVSRS_OP_WRITE,
    NVSRS_OP_SAVE, NVSRS_OP_RESTORE} nvsrs_op_t;
endpackage

// ---- nvsrs_strobe.sv ----
// nvsrs_strobe: one chip-enable-strobed memory cycle on the pins
// assumes registered pin outputs and a two-flop synchronised data input
`timescale 1ns/1ns
`default_nettype none
module nvsrs_strobe #(
  parameter int LOW_CYC = nvsrs_pkg::ACCESS_CYC,
  parameter int GAP_CYC = nvsrs_pkg::RECOVER_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic wr,
  input wire logic [nvsrs_pkg::ADDR_W-1:0] addr,
  input wire logic [nvsrs_pkg::DATA_W-1:0] wdata,
  input wire logic [nvsrs_pkg::DATA_W-1:0] din_sync,
  output logic busy,
  output logic done,
  output logic [nvsrs_pkg::DATA_W-1:0] rdata,
  output logic [nvsrs_pkg::ADDR_W-1:0] addr_bus,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [nvsrs_pkg::DATA_W-1:0] data_o,
  output logic data_oe
);
  import nvsrs_pkg::*;
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_GAP} nvsrs_stb_t;
  nvsrs_stb_t st_q;
  logic [7:0] cnt_q;
  logic wr_q;

  initial begin
    if (LOW_CYC < CE_LOW_CYC + 2 || GAP_CYC < 1 || LOW_CYC > 200)
      $error("nvsrs_strobe: bad timing parameters");
  end

  // --------------------------------------------------------------
  // strobe sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q <= ST_LOW;
            busy <= 1'b1;
            wr_q <= wr;
            cnt_q <= 8'(LOW_CYC);
          end
        end
        ST_LOW: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q <= ST_GAP;
            cnt_q <= 8'(GAP_CYC);
          end
        end
        ST_GAP: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // pins: address set with the falling strobe, held past its rise
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_bus <= '0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      data_o <= '0;
      data_oe <= 1'b0;
    end else if (st_q == ST_IDLE && start) begin
      addr_bus <= addr; // R16
      data_o <= wdata;
      ce_n <= 1'b0; // R5
      we_n <= !wr; // R3
      oe_n <= wr;
      data_oe <= wr;
    end else if (st_q == ST_LOW && cnt_q == 8'h01) begin
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
    end else if (st_q == ST_GAP && cnt_q == 8'h01) begin
      data_oe <= 1'b0;
    end
  end

  // sample the read byte before the strobe rises
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (st_q == ST_LOW && cnt_q == 8'h01 && !wr_q) begin
      rdata <= din_sync; // R23
    end
  end

  ce_width_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(ce_n) |=> !ce_n [*2]) else $error("strobe low too short"); // R14
  addr_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !ce_n |=> $stable(addr_bus) || $rose(ce_n))
    else $error("address moved under strobe"); // R16
endmodule
`default_nettype wire

// ---- nvsrs_host.sv ----
// nvsrs_host: host controller issuing reads, writes, saves and restores
// assumes a byte-wide nonvolatile SRAM on the pins and a same-clock user
//
// Notes on behaviour
// R1: host issues five fixed prefix reads in order before the selecting sixth.
// R2: sixth address 0fc0 starts a save, 0c63 starts a restore.
// R3: write strobe stays high through all six sequence reads.
// R4: device matches only address bits 13..0; bit 14 is don't care.
// R5: each step is a chip-enable-strobed read cycle.
// R6: device accepts the sequence with output enable high or low.
// R7: a started transfer runs alone; the host leaves the pins idle.
// R8: device floats data within 600 ns after the sixth strobe.
// R9: a save finishes within 10 ms; host waits that long.
// R10: a software restore finishes within 20 us; host waits that long.
// R11: device refuses saves while supply is below the trip level.
// R12: power-up restore finishes within 650 us of the supply crossing.
// R13: repeated strobes to one address count as separate cycles.
// R14: a strobe low pulse of at least 20 ns registers a step.
// R15: host never issues the reserved test sequence ending 339c.
// R16: address set by the falling strobe, held until it rises.
// R17: device floats data when write is low at strobe fall.
// R18: during a transfer normal reads and writes are disabled.
// R19: any other access mid-sequence aborts it.
// R20: restore clears the SRAM then copies nonvolatile data in.
// R21: save erases nonvolatile data then programs it from SRAM.
// R22: a mismatching read returns the matcher to idle or step two.
// R23: the five prefix reads return the stored byte at each address.
`timescale 1ns/1ns
`default_nettype none
module nvsrs_host #(
  parameter int SAVE_WAIT = nvsrs_pkg::SAVE_CYC,
  parameter int RESTORE_WAIT = nvsrs_pkg::RESTORE_CYC,
  parameter int POWERUP_WAIT = nvsrs_pkg::POWERUP_COPY_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire nvsrs_pkg::nvsrs_op_t req_op,
  input wire logic [nvsrs_pkg::ADDR_W-1:0] req_addr,
  input wire logic [nvsrs_pkg::DATA_W-1:0] req_wdata,
  input wire logic supply_ok,
  output logic req_ready,
  output logic resp_valid,
  output logic resp_refused,
  output logic [nvsrs_pkg::DATA_W-1:0] resp_rdata,
  output logic [nvsrs_pkg::ADDR_W-1:0] addr_bus,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  input wire logic [nvsrs_pkg::DATA_W-1:0] data_i,
  output logic [nvsrs_pkg::DATA_W-1:0] data_o,
  output logic data_oe
);
  import nvsrs_pkg::*;

  typedef enum logic [2:0] {
    HS_POWERUP, HS_IDLE, HS_CYCLE, HS_SEQ, HS_WAIT
  } nvsrs_state_t;

  nvsrs_state_t st_q;
  logic [WAIT_W-1:0] wait_q;
  logic [2:0] step_q;
  nvsrs_op_t op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] din_meta_q;
  logic [DATA_W-1:0] din_sync_q;
  logic sup_meta_q;
  logic sup_sync_q;
  logic stb_start_q;
  logic stb_busy;
  logic stb_done;
  logic [DATA_W-1:0] stb_rdata;
  logic [ADDR_W-1:0] seq_addr;
  logic seq_wr;

  initial begin
    if (SAVE_WAIT < 2 || RESTORE_WAIT < 2 || POWERUP_WAIT < 2 ||
        SAVE_WAIT >= (1 << WAIT_W) || POWERUP_WAIT >= (1 << WAIT_W) ||
        RESTORE_WAIT >= (1 << WAIT_W))
      $error("nvsrs_host: wait count out of range");
  end

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      din_meta_q <= '0;
      din_sync_q <= '0;
      sup_meta_q <= 1'b0;
      sup_sync_q <= 1'b0;
    end else begin
      din_meta_q <= data_i;
      din_sync_q <= din_meta_q;
      sup_meta_q <= supply_ok;
      sup_sync_q <= sup_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // step address: prefix, then selector; bit 14 left zero
  // ----------------------------------------------------------------
  always_comb begin
    seq_addr = '0;
    seq_wr = 1'b0;
    unique case (step_q)
      3'h0: seq_addr = {1'b0, SEQ_A1}; // R1
      3'h1: seq_addr = {1'b0, SEQ_A2};
      3'h2: seq_addr = {1'b0, SEQ_A3};
      3'h3: seq_addr = {1'b0, SEQ_A4};
      3'h4: seq_addr = {1'b0, SEQ_A5};
      default: seq_addr = (op_q == NVSRS_OP_SAVE) ?
        {1'b0, SEQ_SAVE} : {1'b0, SEQ_RESTORE}; // R2 R15
    endcase
    if (st_q == HS_CYCLE) begin
      seq_addr = addr_q;
      seq_wr = (op_q == NVSRS_OP_WRITE);
    end
  end

  // ----------------------------------------------------------------
  // main controller
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= HS_POWERUP;
      wait_q <= WAIT_W'(POWERUP_WAIT);
      step_q <= 3'h0;
      op_q <= NVSRS_OP_READ;
      addr_q <= '0;
      wdata_q <= '0;
      stb_start_q <= 1'b0;
      req_ready <= 1'b0;
      resp_valid <= 1'b0;
      resp_refused <= 1'b0;
      resp_rdata <= '0;
    end else begin
      stb_start_q <= 1'b0;
      resp_valid <= 1'b0;
      resp_refused <= 1'b0;
      unique case (st_q)
        HS_POWERUP: begin
          if (!sup_sync_q) begin
            wait_q <= WAIT_W'(POWERUP_WAIT);
          end else if (wait_q == WAIT_W'(1)) begin
            st_q <= HS_IDLE; // R12
            req_ready <= 1'b1;
          end else begin
            wait_q <= wait_q - WAIT_W'(1);
          end
        end
        HS_IDLE: begin
          if (req_valid) begin
            req_ready <= 1'b0;
            op_q <= req_op;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            step_q <= 3'h0;
            if (req_op == NVSRS_OP_SAVE && !sup_sync_q) begin
              req_ready <= 1'b1; // R11
              resp_valid <= 1'b1;
              resp_refused <= 1'b1;
            end else begin
              st_q <= (req_op == NVSRS_OP_READ ||
                req_op == NVSRS_OP_WRITE) ? HS_CYCLE : HS_SEQ;
              stb_start_q <= 1'b1;
            end
          end
        end
        HS_CYCLE: begin
          if (stb_done) begin
            st_q <= HS_IDLE;
            req_ready <= 1'b1;
            resp_valid <= 1'b1;
            resp_rdata <= stb_rdata;
          end
        end
        HS_SEQ: begin
          if (stb_done) begin
            if (step_q == 3'h5) begin
              st_q <= HS_WAIT; // R7 R18
              wait_q <= (op_q == NVSRS_OP_SAVE) ?
                WAIT_W'(SAVE_WAIT) : WAIT_W'(RESTORE_WAIT); // R9 R10
            end else begin
              step_q <= step_q + 3'h1; // R19
              stb_start_q <= 1'b1;
            end
          end
        end
        HS_WAIT: begin
          if (!sup_sync_q && op_q == NVSRS_OP_SAVE) begin
            st_q <= HS_POWERUP; // R11
            wait_q <= WAIT_W'(POWERUP_WAIT);
            resp_valid <= 1'b1;
            resp_refused <= 1'b1;
          end else if (wait_q == WAIT_W'(1)) begin
            st_q <= HS_IDLE;
            req_ready <= 1'b1;
            resp_valid <= 1'b1;
          end else begin
            wait_q <= wait_q - WAIT_W'(1);
          end
        end
      endcase
    end
  end

  nvsrs_strobe u_strobe (
    .clk(clk),
    .resetn(resetn),
    .start(stb_start_q),
    .wr(seq_wr),
    .addr(seq_addr),
    .wdata(wdata_q),
    .din_sync(din_sync_q),
    .busy(stb_busy),
    .done(stb_done),
    .rdata(stb_rdata),
    .addr_bus(addr_bus),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n),
    .data_o(data_o),
    .data_oe(data_oe)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  seq_no_write_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HS_SEQ |-> we_n) else $error("write during sequence"); // R3
  wait_pins_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HS_WAIT |-> ce_n && !data_oe)
    else $error("pins active during transfer"); // R7
  save_refused_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HS_IDLE && req_valid && req_op == NVSRS_OP_SAVE && !sup_sync_q
    |=> resp_refused && st_q == HS_IDLE)
    else $error("save not refused at low supply"); // R11
  seq_addr_ok_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HS_SEQ && step_q == 3'h0 && $fell(ce_n) |->
    addr_bus[13:0] == SEQ_A1) else $error("bad first address"); // R1
  no_test_seq_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HS_SEQ && $fell(ce_n) |-> addr_bus[13:0] != SEQ_TEST)
    else $error("test sequence issued"); // R15
  select_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HS_SEQ && step_q == 3'h5 && $fell(ce_n) |->
    addr_bus[13:0] == ((op_q == NVSRS_OP_SAVE) ? SEQ_SAVE : SEQ_RESTORE))
    else $error("bad selector address"); // R2
  powerup_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HS_POWERUP |-> ce_n && !req_ready)
    else $error("access before power-up copy"); // R12
  wait_ready_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q == HS_WAIT |-> !req_ready) else $error("ready mid transfer"); // R18
  strobe_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    stb_start_q |-> !stb_busy) else $error("strobe restarted busy"); // R5

  save_cov: cover property (@(posedge clk) disable iff (!resetn)
    st_q == HS_WAIT && op_q == NVSRS_OP_SAVE && wait_q == WAIT_W'(1));
  restore_cov: cover property (@(posedge clk) disable iff (!resetn)
    st_q == HS_WAIT && op_q == NVSRS_OP_RESTORE && wait_q == WAIT_W'(1));
  read_cov: cover property (@(posedge clk) disable iff (!resetn)
    resp_valid && op_q == NVSRS_OP_READ);
  refuse_cov: cover property (@(posedge clk) disable iff (!resetn)
    resp_refused);
endmodule
`default_nettype wire

// ---- nvsrs_mem_model.sv ----
// nvsrs_mem_model: behavioural byte-wide nonvolatile sram facing the host
// assumes the bench resolves the data wire and drives the supply sense
`timescale 1ns/1ns
`default_nettype none
module nvsrs_mem_model
  import nvsrs_pkg::*;
#(
  parameter int SAVE_NS = 500,
  parameter int RESTORE_NS = 150,
  parameter int POWERUP_NS = 500
) (
  input wire logic supply_ok,
  input wire logic [14:0] addr_bus,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_o,
  output logic dq_oe,
  output logic [7:0] viol,
  output logic [7:0] saves,
  output logic [7:0] restores
);
  localparam logic [13:0] PRE [0:4] = '{SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4, SEQ_A5};
  logic [7:0] mem [0:32767];
  logic [7:0] nv [0:32767];
  logic [7:0] fuzz = 8'ha5;
  logic [2:0] step = 3'h0;
  logic [1:0] kind = 2'h0;
  logic busy = 1'b0;
  logic seen = 1'b0;
  logic wr_pend = 1'b0;
  logic [14:0] addr_l;
  event go;
  initial begin
    viol = 8'h00;
    saves = 8'h00;
    restores = 8'h00;
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
      nv[i] = 8'(i);
    end
  end
  // ----------------------------------------------------------------
  // sequence matcher, stepped by the chip enable fall
  // ----------------------------------------------------------------
  always @(negedge ce_n) begin
    addr_l = addr_bus;
    seen = 1'b1;
    wr_pend = (we_n === 1'b0);
    if (busy) begin
      viol = viol + 8'h01;
    end else if (we_n !== 1'b1) begin
      step = 3'h0;
    end else if (step == 3'h5) begin
      step = 3'h0;
      kind = (addr_bus[13:0] == SEQ_SAVE) ? 2'h2 : 2'h3;
      if (addr_bus[13:0] == SEQ_SAVE || addr_bus[13:0] == SEQ_RESTORE) begin
        -> go;
      end
      if (addr_bus[13:0] == SEQ_TEST) begin
        viol = viol + 8'h01;
      end
    end else if (addr_bus[13:0] == PRE[step]) begin
      step = step + 3'h1;
    end else begin
      step = (addr_bus[13:0] == SEQ_A1) ? 3'h1 : 3'h0;
    end
  end
  always @(negedge we_n) begin
    if (ce_n === 1'b0) wr_pend = 1'b1;
  end
  always @(posedge ce_n) begin
    if (seen && addr_bus !== addr_l) viol = viol + 8'h01;
    if (wr_pend && !busy) mem[addr_bus] = dq_in;
    wr_pend = 1'b0;
  end
  always @(posedge supply_ok) begin
    kind = 2'h1;
    -> go;
  end
  // ----------------------------------------------------------------
  // transfers run alone; a save watches the supply throughout
  // ----------------------------------------------------------------
  always begin
    @(go);
    busy = 1'b1;
    if (kind == 2'h2) begin
      for (int t = 0; t < SAVE_NS && supply_ok; t += 10) #10;
      if (supply_ok) begin
        nv = mem;
        saves = saves + 8'h01;
      end
    end else begin
      #(kind == 2'h3 ? RESTORE_NS : POWERUP_NS);
      mem = nv;
      restores = restores + 8'h01;
    end
    busy = 1'b0;
  end
  always #10 fuzz = ~fuzz;
  assign dq_oe = !ce_n && !oe_n && we_n && !busy;
  assign dq_o = dq_oe ? mem[addr_bus] : fuzz;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// tb_top: self-checking bench for the nonvolatile save/restore host
// assumes the behavioural memory model sits on the pins
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import nvsrs_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  nvsrs_op_t req_op = NVSRS_OP_READ;
  logic [14:0] req_addr = 15'h0000;
  logic [7:0] req_wdata = 8'h00;
  logic supply_ok = 1'b0;
  logic req_ready, resp_valid, resp_refused, ce_n, we_n, oe_n;
  logic data_oe, dq_oe, refused;
  logic [7:0] resp_rdata, data_o, dq_o, data_i, viol, saves, restores, rd;
  logic [14:0] addr_bus;
  int errors = 0;
  int checked = 0;
  always #10 clk = ~clk;
  assign data_i = (data_oe === 1'b1) ? data_o : dq_o;
  nvsrs_host #(.SAVE_WAIT(30), .RESTORE_WAIT(10), .POWERUP_WAIT(30))
      nvsrs_host_inst (.clk(clk), .resetn(resetn), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
      .supply_ok(supply_ok), .req_ready(req_ready), .resp_valid(resp_valid),
      .resp_refused(resp_refused), .resp_rdata(resp_rdata),
      .addr_bus(addr_bus), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .data_i(data_i), .data_o(data_o), .data_oe(data_oe));
  nvsrs_mem_model nvsrs_mem_model_inst (.supply_ok(supply_ok),
      .addr_bus(addr_bus), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
      .dq_in(data_i), .dq_o(dq_o), .dq_oe(dq_oe), .viol(viol),
      .saves(saves), .restores(restores));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen,
      input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 2000) begin
      chk("timeout", 8'h01, 8'h00);
      stop_test();
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge clk);
      guard(n);
    end
  endtask
  task automatic req(input nvsrs_op_t op, input logic [14:0] a,
      input logic [7:0] d, input int drop_at);
    int n;
    wait_ready();
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    @(negedge clk);
    while (resp_valid !== 1'b1) begin
      @(posedge clk);
      guard(n);
      if (n == drop_at) supply_ok <= 1'b0;
      @(negedge clk);
    end
    refused = resp_refused;
    rd = resp_rdata;
  endtask
  task automatic supply_up();
    @(posedge clk);
    supply_ok <= 1'b1;
    repeat (40) @(posedge clk);
  endtask
  always @(negedge clk) begin
    if (data_oe === 1'b1) chk("bus_free", {7'h00, dq_oe}, 8'h00);
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    @(negedge clk);
    chk("ready_early", {7'h00, req_ready}, 8'h00);
    wait_ready();
    chk("powerup_copies", restores, 8'h01);
    req(NVSRS_OP_READ, 15'h0123, 8'h00, 0);
    chk("recalled", rd, 8'h23);
  endtask
  task automatic t_rdwr();
    req(NVSRS_OP_WRITE, 15'h4abc, 8'hc5, 0);
    req(NVSRS_OP_READ, 15'h4abc, 8'h00, 0);
    chk("rd_hi", rd, 8'hc5);
    req(NVSRS_OP_READ, 15'h0abc, 8'h00, 0);
    chk("rd_lo", rd, 8'hbc);
  endtask
  task automatic t_save_restore();
    req(NVSRS_OP_WRITE, 15'h0100, 8'h77, 0);
    req(NVSRS_OP_SAVE, 15'h0000, 8'h00, 0);
    chk("save_ok", {7'h00, refused}, 8'h00);
    chk("saves", saves, 8'h01);
    req(NVSRS_OP_WRITE, 15'h0100, 8'h11, 0);
    req(NVSRS_OP_RESTORE, 15'h0000, 8'h00, 0);
    chk("restores", restores, 8'h02);
    req(NVSRS_OP_READ, 15'h0100, 8'h00, 0);
    chk("restored", rd, 8'h77);
  endtask
  task automatic t_save_low();
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (4) @(posedge clk);
    req(NVSRS_OP_SAVE, 15'h0000, 8'h00, 0);
    chk("low_refused", {7'h00, refused}, 8'h01);
    chk("saves_low", saves, 8'h01);
    supply_up();
    req(NVSRS_OP_READ, 15'h0100, 8'h00, 0);
    chk("after_low", rd, 8'h77);
  endtask
  task automatic t_save_abort();
    req(NVSRS_OP_WRITE, 15'h0100, 8'h99, 0);
    req(NVSRS_OP_SAVE, 15'h0000, 8'h00, 46);
    chk("abort_refused", {7'h00, refused}, 8'h01);
    chk("saves_abort", saves, 8'h01);
    supply_up();
    req(NVSRS_OP_READ, 15'h0100, 8'h00, 0);
    chk("after_abort", rd, 8'h77);
    req(NVSRS_OP_WRITE, 15'h0100, 8'h55, 0);
    req(NVSRS_OP_SAVE, 15'h0000, 8'h00, 10);
    chk("seq_drop_refused", {7'h00, refused}, 8'h01);
    chk("saves_seq_drop", saves, 8'h01);
    supply_up();
    req(NVSRS_OP_READ, 15'h0100, 8'h00, 0);
    chk("after_seq_drop", rd, 8'h77);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    supply_ok <= 1'b1;
    t_powerup();
    t_rdwr();
    t_save_restore();
    t_save_low();
    t_save_abort();
    chk("model_viol", viol, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
